// ---- rtl/hcob_map.svh ----
// register offsets, field positions and reset values of the output port bank
`ifndef HCOB_MAP_SVH
`define HCOB_MAP_SVH
`define HCOB_PORT_LO_OFF 12'h000
`define HCOB_PORT_HI_OFF 12'h004
`define HCOB_CSR_OFF 12'h000
`define HCOB_IRQ_STAT_OFF 12'h004
`define HCOB_IRQ_EN_OFF 12'h008
`define HCOB_IRQ_CLR_OFF 12'h00C
`define HCOB_CSR_TEST_BIT 0
`define HCOB_CSR_FAIL_BIT 1
`define HCOB_CSR_AM_BIT 2
`define HCOB_CSR_RESET 32'h0000_0002
`define HCOB_PORT_RESET 32'h0000_0000
`define HCOB_EV_PORT_WR 0
`define HCOB_EV_TEST_CHG 1
`define HCOB_EV_REFUSED 2
`define HCOB_EV_NUM 3
`endif

// ---- rtl/hcob_pkg.sv ----
// types shared by the output port bank
package hcob_pkg;
  typedef struct packed {
    logic [7:0] drive_high;
    logic [7:0] drive_en;
  } hcob_pin_byte_t;
  typedef struct packed {
    logic test_mode;
    logic fail_led;
    logic nonpriv;
  } hcob_csr_t;
  typedef enum logic {
    HCOB_MODE_SRC_HIZ,
    HCOB_MODE_SRC_SINK
  } hcob_mode_t;
endpackage : hcob_pkg

// ---- rtl/hcob_drive_byte.sv ----
// maps one written data byte to driver pin levels and enables
`timescale 1ns/1ps
module hcob_drive_byte
  import hcob_pkg::*;
#(
  parameter bit POSITIVE_TRUE = 1'b1
) (
  input wire logic [7:0] data_i,
  input wire logic mode_sink_i,
  input wire logic force_off_i,
  output hcob_pin_byte_t pins_o
);
  wire [7:0] active = POSITIVE_TRUE ? data_i : ~data_i;
  // source/sink always drives; source-only floats when inactive
  wire [7:0] en_w = mode_sink_i ? 8'hFF : active;
  // off means High-Z in source-only, sinking in source/sink mode
  assign pins_o.drive_high = force_off_i ? 8'h00 : active;
  assign pins_o.drive_en = force_off_i ? (mode_sink_i ? 8'hFF : 8'h00) : en_w;
endmodule : hcob_drive_byte

// ---- rtl/hcob_port_bank.sv ----
// high current output port bank with APB register access
// Notes on behaviour
// - sixty-four outputs as eight byte ports
// - byte, halfword, word writes via strobes
// - static select supervisory or nonprivileged access
// - status register has its own base
// - test mode forces all outputs off
// - fail led on at reset until cleared
// - per-byte static source-only or source/sink choice
// - positive source-only: zero float, one source
// - negative source-only: zero source, one float
// - positive source/sink: zero sink, one source
// - negative source/sink: zero source, one sink
`timescale 1ns/1ps
`include "hcob_map.svh"
module hcob_port_bank
  import hcob_pkg::*;
#(
  parameter bit POSITIVE_TRUE = 1'b1,
  parameter logic [15:0] PORT_BASE = 16'h1000,
  parameter logic [15:0] CSR_BASE = 16'h2000
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [2:0] PPROT_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic NONPRIV_SEL_I,
  input wire logic [7:0] MODE_SINK_I,
  output logic [63:0] OUT_HIGH_O,
  output logic [63:0] OUT_EN_O,
  output logic FAIL_LED_O,
  output logic TEST_MODE_O,
  output logic IRQ_O
);
  logic [63:0] port_q;
  hcob_csr_t csr_q;
  logic [`HCOB_EV_NUM-1:0] stat_q;
  logic [`HCOB_EV_NUM-1:0] irq_en_q;
  logic [1:0] am_sync_q;
  logic [7:0] mode_s1_q;
  logic [7:0] mode_s2_q;
  logic [7:0] wr_byte_strb;

  // static straps still cross in through two flops
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      am_sync_q <= 2'h0;
      mode_s1_q <= 8'h00;
      mode_s2_q <= 8'h00;
    end else begin
      am_sync_q <= {am_sync_q[0], NONPRIV_SEL_I};
      mode_s1_q <= MODE_SINK_I;
      mode_s2_q <= mode_s1_q;
    end
  end

  // pprot[0] high = privileged; nonprivileged setting also admits supervisory
  wire priv_ok = am_sync_q[1] | PPROT_I[0];
  wire access = PSEL_I & PENABLE_I;
  wire port_hit = PADDR_I[15:3] == PORT_BASE[15:3];
  wire csr_hit = PADDR_I[15:4] == CSR_BASE[15:4];
  wire refuse = access & (~priv_ok | ~(port_hit | csr_hit));
  wire wr_ok = access & PWRITE_I & priv_ok;
  wire port_wr = wr_ok & port_hit;
  wire csr_wr = wr_ok & csr_hit;
  wire [11:0] loc = {8'h00, PADDR_I[3:0]};
  wire [11:0] ploc = {9'h000, PADDR_I[2:0]};
  wire hi_word = ploc == `HCOB_PORT_HI_OFF;
  wire csr_sel = csr_wr & (loc == `HCOB_CSR_OFF);
  wire en_sel = csr_wr & (loc == `HCOB_IRQ_EN_OFF);
  wire clr_sel = csr_wr & (loc == `HCOB_IRQ_CLR_OFF);
  wire test_next = PSTRB_I[0] ? PWDATA_I[`HCOB_CSR_TEST_BIT] : csr_q.test_mode;

  assign wr_byte_strb = port_wr ? (hi_word ? {PSTRB_I, 4'h0} : {4'h0, PSTRB_I}) : 8'h00;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_port
      always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
          port_q[g*8 +: 8] <= 8'h00;
        end else if (wr_byte_strb[g]) begin
          port_q[g*8 +: 8] <= PWDATA_I[(g%4)*8 +: 8];
        end
      end
      hcob_drive_byte #(
        .POSITIVE_TRUE(POSITIVE_TRUE)
      ) u_drive (
        .data_i(port_q[g*8 +: 8]),
        .mode_sink_i(mode_s2_q[g]),
        .force_off_i(csr_q.test_mode),
        .pins_o({OUT_HIGH_O[g*8 +: 8], OUT_EN_O[g*8 +: 8]})
      );
    end
  endgenerate

  wire [`HCOB_EV_NUM-1:0] ev;
  assign ev[`HCOB_EV_PORT_WR] = |wr_byte_strb;
  assign ev[`HCOB_EV_TEST_CHG] = csr_sel & (test_next != csr_q.test_mode);
  assign ev[`HCOB_EV_REFUSED] = refuse;
  wire [`HCOB_EV_NUM-1:0] clr_mask = clr_sel ? PWDATA_I[`HCOB_EV_NUM-1:0] : '0;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      csr_q <= '{test_mode: 1'b0, fail_led: 1'b1, nonpriv: 1'b0};
      stat_q <= '0;
      irq_en_q <= '0;
    end else begin
      if (csr_sel && PSTRB_I[0]) begin
        csr_q.test_mode <= PWDATA_I[`HCOB_CSR_TEST_BIT];
        csr_q.fail_led <= PWDATA_I[`HCOB_CSR_FAIL_BIT];
      end
      csr_q.nonpriv <= am_sync_q[1];
      if (en_sel) begin
        irq_en_q <= PWDATA_I[`HCOB_EV_NUM-1:0];
      end
      // a new event wins over a clear in the same cycle
      stat_q <= (stat_q & ~clr_mask) | ev;
    end
  end

  wire [31:0] csr_rd = {29'h0, csr_q.nonpriv, csr_q.fail_led, csr_q.test_mode};
  wire [31:0] rd_mux =
    port_hit ? (hi_word ? port_q[63:32] : port_q[31:0]) :
    (loc == `HCOB_CSR_OFF) ? csr_rd :
    (loc == `HCOB_IRQ_STAT_OFF) ? {29'h0, stat_q} :
    (loc == `HCOB_IRQ_EN_OFF) ? {29'h0, irq_en_q} : 32'h0;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rd_mux;
    end
  end

  // zero-wait slave; refused access gets an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = refuse;
  assign FAIL_LED_O = csr_q.fail_led;
  assign TEST_MODE_O = csr_q.test_mode;
  assign IRQ_O = |(stat_q & irq_en_q);

  a_test_forces_off: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    csr_q.test_mode |-> (OUT_HIGH_O == 64'h0)) else $error("output high during test");
  a_fail_led_reset: assert property (@(posedge CORE_CLK_I)
    $rose(RESET_N_I) |-> FAIL_LED_O) else $error("fail led off after reset");
  a_fail_led_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    $fell(FAIL_LED_O) |-> $past(csr_sel)) else $error("fail led cleared without write");
  a_test_enter: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    csr_sel && PSTRB_I[0] && PWDATA_I[0] |=> TEST_MODE_O) else $error("test mode not entered");
  a_port_write: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    port_wr && !hi_word && PSTRB_I[0] |=> port_q[7:0] == $past(PWDATA_I[7:0]))
    else $error("port byte not stored");
  a_strobe_keep: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    port_wr && !hi_word && !PSTRB_I[1] |=> $stable(port_q[15:8])) else $error("unstrobed byte changed");
  a_priv_refuse: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    access && !am_sync_q[1] && !PPROT_I[0] && PWRITE_I |=> $stable(port_q))
    else $error("nonprivileged write accepted");
  a_sink_drive: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    mode_s2_q[0] |-> OUT_EN_O[7:0] == 8'hFF) else $error("source/sink byte floated");
  a_srcz_map: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    !mode_s2_q[0] && !csr_q.test_mode |-> OUT_EN_O[0] == (port_q[0] == POSITIVE_TRUE))
    else $error("source-only mapping wrong");
  a_csr_sep: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    port_wr && !csr_hit |=> $stable(TEST_MODE_O)) else $error("port write touched test bit");
endmodule : hcob_port_bank

// ---- testbench/hcob_apb_master.sv ----
// apb master model standing in for the host bus
`timescale 1ns/1ps
module hcob_apb_master (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [15:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o,
  output logic [2:0] pprot_o
);
  initial begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
    pprot_o = 3'h1;
  end
  // aligned 8/16/32 bit writes through strobes
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [2:0] p, output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    pprot_o <= p;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    // no cycle limit here; only the bench watchdog ends a stuck wait
    while (pready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released data must not look valid
    pwdata_o <= ~d;
  endtask : xfer
endmodule : hcob_apb_master

// ---- testbench/hcob_port_bank_tb.sv ----
// self-checking bench of the output port bank
`timescale 1ns/1ps
`include "hcob_map.svh"
module hcob_port_bank_tb;
  logic clk = 0, rst_n = 0, psel, penable, pwrite, pready, pslverr, nonpriv = 0, fail_led, test_mode, irq, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  logic [7:0] mode = 8'h0F;
  logic [63:0] out_high, out_en, img = '0;
  logic [63:0] out_high_n, out_en_n;
  int n_mismatch = 0, samples_checked = 0;
  always #5 clk = ~clk;
  hcob_port_bank DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PPROT_I(pprot),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .NONPRIV_SEL_I(nonpriv),
    .MODE_SINK_I(mode), .OUT_HIGH_O(out_high), .OUT_EN_O(out_en), .FAIL_LED_O(fail_led),
    .TEST_MODE_O(test_mode), .IRQ_O(irq));
  // negative-true copy on the same bus; only its pins are judged
  hcob_port_bank #(.POSITIVE_TRUE(1'b0)) DUT_NEG (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PPROT_I(pprot), .PRDATA_O(), .PREADY_O(), .PSLVERR_O(), .NONPRIV_SEL_I(nonpriv),
    .MODE_SINK_I(mode), .OUT_HIGH_O(out_high_n), .OUT_EN_O(out_en_n), .FAIL_LED_O(),
    .TEST_MODE_O(), .IRQ_O());
  hcob_apb_master m (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .pstrb_o(pstrb), .pprot_o(pprot));
  task chk(input logic [63:0] got, input logic [63:0] exp, input string t);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, t);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    m.xfer(1'b1, a, d, s, 3'h1, rd, err);
    repeat (2) @(posedge clk);
  endtask : wr
  // sink bytes drive both ways, source-only bytes float on zero in the positive copy and on one in the negative copy
  task pins(input logic off);
    logic [63:0] sk, ee;
    for (int i = 0; i < 64; i++) sk[i] = mode[i/8];
    ee = off ? sk : (sk | img);
    chk(out_en, ee, "pin enable");
    chk(out_high & out_en, off ? 64'h0 : img & ee, "pin level");
    chk(out_en_n, off ? sk : (sk | ~img), "neg pin enable");
    chk(out_high_n & out_en_n, off ? 64'h0 : ~img & (sk | ~img), "neg pin level");
  endtask : pins
  task t_reset;
    chk(fail_led, 1'b1, "led at reset");
    chk(test_mode, 1'b0, "test at reset");
    m.xfer(1'b0, 16'h2000, 32'h0, 4'h0, 3'h1, rd, err);
    chk(rd, `HCOB_CSR_RESET, "csr reset");
    pins(1'b0);
  endtask : t_reset
  task t_ports;
    wr(16'h1000, 32'h0000_00A5, 4'h1);
    wr(16'h1000, 32'h817E_0000, 4'hC);
    wr(16'h1004, 32'hF00F_C33C, 4'hF);
    img = 64'hF00F_C33C_817E_00A5;
    pins(1'b0);
    m.xfer(1'b0, 16'h1004, 32'h0, 4'h0, 3'h1, rd, err);
    chk(rd, 32'hF00F_C33C, "high word readback");
    m.xfer(1'b0, 16'h1000, 32'h0, 4'h0, 3'h1, rd, err);
    chk(rd, 32'h817E_00A5, "low word readback");
    mode <= 8'hF0;
    repeat (4) @(posedge clk);
    pins(1'b0);
  endtask : t_ports
  task t_test;
    wr(16'h2000, 32'h3, 4'hF);
    chk(test_mode, 1'b1, "test set");
    pins(1'b1);
    wr(16'h2000, 32'h0, 4'hF);
    chk(fail_led, 1'b0, "led off");
    pins(1'b0);
  endtask : t_test
  task t_priv;
    m.xfer(1'b1, 16'h1000, 32'h0, 4'hF, 3'h0, rd, err);
    chk(err, 1'b1, "user refused");
    m.xfer(1'b0, 16'h3000, 32'h0, 4'h0, 3'h1, rd, err);
    chk(err, 1'b1, "unmapped");
    nonpriv <= 1'b1;
    repeat (4) @(posedge clk);
    m.xfer(1'b1, 16'h1000, 32'h0, 4'h1, 3'h0, rd, err);
    repeat (2) @(posedge clk);
    chk(err, 1'b0, "user allowed");
    img[7:0] = 8'h00;
    pins(1'b0);
  endtask : t_priv
  task t_irq;
    wr(16'h200C, 32'h7, 4'hF);
    wr(16'h2008, 32'h1, 4'hF);
    chk(irq, 1'b0, "irq idle");
    wr(16'h1000, 32'h0, 4'h1);
    chk(irq, 1'b1, "irq raised");
    m.xfer(1'b0, 16'h2004, 32'h0, 4'h0, 3'h1, rd, err);
    chk(rd, 32'h0000_0001, "irq status");
    wr(16'h2008, 32'h0, 4'hF);
    chk(irq, 1'b0, "irq masked");
    wr(16'h2008, 32'h1, 4'hF);
    wr(16'h200C, 32'h1, 4'hF);
    chk(irq, 1'b0, "irq cleared");
  endtask : t_irq
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_ports;
    t_test;
    t_priv;
    t_irq;
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule : hcob_port_bank_tb
